// ===== inc/vram_xfer_pkg.sv
package vram_xfer_pkg;
    // ==========================================================
    // Geometry
    localparam int WORD_W = 16;
    localparam int BUF_AW = 8;
    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam logic [8:0] FULL_WORDS = 9'h100;
    localparam logic [8:0] HALF_WORDS = 9'h080;
    // ==========================================================
    // Cycle kinds presented on the kind pins at row strobe fall
    localparam logic [2:0] KIND_SETUP = 3'h1;
    localparam logic [2:0] KIND_FULL_RD = 3'h2;
    localparam logic [2:0] KIND_SPLIT_RD = 3'h3;
    localparam logic [2:0] KIND_FULL_WR = 3'h4;
    localparam logic [2:0] KIND_SPLIT_WR = 3'h5;
    // ==========================================================
    // Serial counter and stop register
    localparam logic [6:0] JUMP_LOW7 = 7'h7F;
    localparam logic [7:0] STOP_RST = 8'h7F;
    localparam int STOP_FLD_LSB = 4;
    // ==========================================================
    // Register map and fields
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_CTRL = 12'h004;
    localparam int CTRL_SER_EN = 0;
    localparam int CTRL_MODE_CLR = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int ST_CNT_LSB = 0;
    localparam int ST_STOP_LSB = 8;
    localparam int ST_PEND_LSB = 16;
    localparam int ST_PEND_V = 23;
    localparam int ST_SRS = 24;
    localparam int ST_WRMODE = 25;
    localparam int ST_BUSY = 26;
endpackage

// ===== inc/shift_buffer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface shift_buffer_if;
    logic [7:0] a_addr;
    logic a_we;
    logic [15:0] a_wdata;
    logic [15:0] a_rdata;
    logic [7:0] b_addr;
    logic b_we;
    logic [15:0] b_wdata;
    logic [15:0] b_rdata;
    modport mem (input a_addr, a_we, a_wdata, b_addr, b_we, b_wdata, output a_rdata, b_rdata);
    modport user (output a_addr, a_we, a_wdata, b_addr, b_we, b_wdata, input a_rdata, b_rdata);
endinterface
`default_nettype wire

// ===== rtl/shift_buffer_mem.sv
`timescale 1ns/100ps
`default_nettype none
module shift_buffer_mem
    import vram_xfer_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic clk_i,
    input wire logic ce_i,
    shift_buffer_if.mem bus
);
    // ==========================================================
    // Two ports: the serial side and the transfer engine never wait on each other.
    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] a_rdata_r;
    logic [WORD_W-1:0] b_rdata_r;

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (bus.a_we) begin
                mem_r[bus.a_addr] <= bus.a_wdata;
            end
            if (bus.b_we) begin
                mem_r[bus.b_addr] <= bus.b_wdata;
            end
            a_rdata_r <= mem_r[bus.a_addr];
            b_rdata_r <= mem_r[bus.b_addr];
        end
    end

    assign bus.a_rdata = a_rdata_r;
    assign bus.b_rdata = b_rdata_r;
endmodule
`default_nettype wire

// ===== rtl/vram_split_and_stop_transfer.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (RL1) Split write moves 128 words into segment.
// (RL2) Normal split write: col_bit8 picks row half.
// (RL3) Internal col_bit7 selects idle half's quarter.
// (RL4) Split transfer parks start in pending pointer.
// (RL5) After jump reload, continue in other half.
// (RL6) Controller: full masked write before splits.
// (RL7) Controller: split write well before end.
// (RL8) Setup cycle enters stop-boundary mode.
// (RL9) Stop register latched from address 7..4.
// (RL10) Stop points decoded from stop register.
// (RL11) Upper half stops are lower plus 128.
// (RL12) At stop point load pending pointer.
// (RL13) Stop-mode full read: 256 words, col_bit7.
// (RL14) Physical col_bit8 picks buffer half.
// (RL15) Stop-mode split read: 128 words.
// (RL16) Split read fills idle half from quarter.
// (RL17) Stop-mode split read holds pointer.
// (RL18) After stop reload, resume in other half.
// (RL19) Every shift tick advances the counter.
// (RL20) Counter wraps at last location.
// (RL21) Active half is counter MSB.
module vram_split_and_stop_transfer
    import vram_xfer_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic row_strobe_n_i,
    input wire logic col_strobe_n_i,
    input wire logic [8:0] addr_i,
    input wire logic [2:0] cyc_kind_i,
    input wire logic shift_tick_i,
    input wire logic shift_port_gate_n_i,
    input wire logic [15:0] sdq_i,
    output logic [15:0] sdq_o,
    output logic sdq_oe_o,
    output logic [17:0] array_addr_o,
    output logic array_rd_o,
    output logic array_we_o,
    output logic [15:0] array_wdata_o,
    input wire logic [15:0] array_rdata_i
);
    // ==========================================================
    // Pin synchronisers
    localparam int SW = 32;
    logic [SW-1:0] pin_s1_r;
    logic [SW-1:0] pin_s2_r;
    logic [3:0] edge_s3_r;
    logic row_fall;
    logic col_fall;
    logic tick_rise;
    logic gate_n;
    logic [8:0] addr_s;
    logic [2:0] kind_s;
    logic [15:0] sdq_s;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_s1_r <= {SW{1'b1}};
            pin_s2_r <= {SW{1'b1}};
            edge_s3_r <= 4'hF;
        end else if (ce_i) begin
            pin_s1_r <= {row_strobe_n_i, col_strobe_n_i, shift_tick_i, shift_port_gate_n_i, addr_i, cyc_kind_i, sdq_i};
            pin_s2_r <= pin_s1_r;
            edge_s3_r <= pin_s2_r[SW-1 -: 4];
        end
    end

    assign row_fall = edge_s3_r[3] & ~pin_s2_r[31];
    assign col_fall = edge_s3_r[2] & ~pin_s2_r[30];
    assign tick_rise = ~edge_s3_r[1] & pin_s2_r[29];
    assign gate_n = pin_s2_r[28];
    assign addr_s = pin_s2_r[27:19];
    assign kind_s = pin_s2_r[18:16];
    assign sdq_s = pin_s2_r[15:0];

    // ==========================================================
    // Register bus
    logic [1:0] ctrl_r;
    logic [31:0] status;
    logic apb_hit;
    logic apb_wr;

    assign apb_hit = (paddr_i == OFF_STATUS) || (paddr_i == OFF_CTRL);
    assign apb_wr = psel_i & penable_i & pwrite_i & (paddr_i == OFF_CTRL);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~apb_hit;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_r <= CTRL_RST;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            // The mode clear bit is a one-shot so a stale write cannot pin the mode off.
            ctrl_r[CTRL_MODE_CLR] <= apb_wr & pwdata_i[CTRL_MODE_CLR];
            if (apb_wr) begin
                ctrl_r[CTRL_SER_EN] <= pwdata_i[CTRL_SER_EN];
            end
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_o <= (paddr_i == OFF_STATUS) ? status :
                            (paddr_i == OFF_CTRL) ? {30'h0, ctrl_r} : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Random port cycle capture
    logic [2:0] kind_r;
    logic [ROW_W-1:0] row_r;
    logic srs_r;
    logic [7:0] stop_r;
    logic busy;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            kind_r <= 3'h0;
            row_r <= 9'h000;
        end else if (ce_i && row_fall) begin
            kind_r <= kind_s;
            row_r <= addr_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            srs_r <= 1'b0;
            stop_r <= STOP_RST;
        end else if (ce_i) begin
            if (row_fall && kind_s == KIND_SETUP) begin
                srs_r <= 1'b1; // [RL8]
                stop_r <= {1'b0, addr_s[STOP_FLD_LSB +: 4], 3'h7}; // [RL9]
            end else if (ctrl_r[CTRL_MODE_CLR]) begin
                srs_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Serial counter
    logic [7:0] cnt_r;
    logic [7:0] start_r;
    logic [6:0] pend_r;
    logic pend_v_r;
    logic wr_mode_r;
    logic at_stop;
    logic at_jump;
    logic reload;
    logic xfer_go;
    logic xfer_split;
    logic xfer_wr;

    assign xfer_go = col_fall && !busy && kind_r >= KIND_FULL_RD && kind_r <= KIND_SPLIT_WR;
    assign xfer_split = (kind_r == KIND_SPLIT_RD) || (kind_r == KIND_SPLIT_WR);
    assign xfer_wr = (kind_r == KIND_FULL_WR) || (kind_r == KIND_SPLIT_WR);
    // Masking only the low seven bits makes each upper-half stop its lower twin plus 128.
    assign at_stop = (cnt_r[6:0] & stop_r[6:0]) == stop_r[6:0]; // [RL10] [RL11]
    assign at_jump = cnt_r[6:0] == JUMP_LOW7;
    assign reload = pend_v_r && (srs_r ? at_stop : at_jump);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_r <= 8'h00;
            start_r <= 8'h00;
            pend_r <= 7'h00;
            pend_v_r <= 1'b0;
            wr_mode_r <= 1'b0;
        end else if (ce_i) begin
            if (xfer_go) begin
                wr_mode_r <= xfer_wr;
                if (xfer_split) begin
                    pend_r <= addr_s[6:0]; // [RL4] [RL17]
                    pend_v_r <= 1'b1;
                end else begin
                    cnt_r <= addr_s[7:0];
                    start_r <= addr_s[7:0];
                    pend_v_r <= 1'b0;
                end
            end
            if (tick_rise && !(xfer_go && !xfer_split)) begin
                if (reload) begin
                    // Jump or stop reload lands in the half that was idle.
                    cnt_r <= {~cnt_r[7], pend_r}; // [RL4] [RL5] [RL12] [RL17] [RL18]
                    start_r <= {~cnt_r[7], pend_r};
                    if (!(xfer_go && xfer_split)) begin
                        pend_v_r <= 1'b0;
                    end
                end else begin
                    cnt_r <= cnt_r + 8'h01; // [RL19] [RL20]
                end
            end
        end
    end

    // ==========================================================
    // Serial port access
    shift_buffer_if buf_bus ();
    logic ser_en;

    assign ser_en = ~gate_n & ctrl_r[CTRL_SER_EN];
    assign buf_bus.a_addr = cnt_r;
    assign buf_bus.a_we = ce_i & tick_rise & ser_en & wr_mode_r;
    assign buf_bus.a_wdata = sdq_s;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sdq_o <= 16'h0000;
            sdq_oe_o <= 1'b0;
        end else if (ce_i) begin
            sdq_oe_o <= ser_en & ~wr_mode_r;
            if (tick_rise && ser_en && !wr_mode_r) begin
                sdq_o <= buf_bus.a_rdata;
            end
        end
    end

    // ==========================================================
    // Transfer engine
    typedef enum logic [1:0] {XF_IDLE, XF_RUN, XF_DRAIN} xf_state_e;
    xf_state_e xf_r;
    logic [8:0] idx_r;
    logic [8:0] n_r;
    logic split_r;
    logic dir_wr_r;
    logic srs_xf_r;
    logic idle_half_r;
    logic ca7_r;
    logic ca8_r;
    logic [7:0] bidx;
    logic [COL_W-1:0] col;
    logic d1_v_r;
    logic d2_v_r;
    logic [7:0] d1_bidx_r;
    logic [7:0] d2_bidx_r;
    logic [COL_W-1:0] d1_col_r;

    assign busy = xf_r != XF_IDLE;
    // The idle half is the complement of the counter MSB and doubles as internal col_bit7.
    assign bidx = split_r ? {idle_half_r, idx_r[6:0]} : idx_r[7:0]; // [RL3] [RL21]
    assign col = (srs_xf_r && !dir_wr_r) ? {bidx[7], ca7_r, bidx[6:0]} : {ca8_r, bidx}; // [RL2] [RL13] [RL14] [RL16]

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xf_r <= XF_IDLE;
            idx_r <= 9'h000;
            n_r <= 9'h000;
            split_r <= 1'b0;
            dir_wr_r <= 1'b0;
            srs_xf_r <= 1'b0;
            idle_half_r <= 1'b0;
            ca7_r <= 1'b0;
            ca8_r <= 1'b0;
        end else if (ce_i) begin
            unique case (xf_r)
                XF_IDLE: begin
                    if (xfer_go) begin
                        xf_r <= XF_RUN;
                        idx_r <= 9'h000;
                        n_r <= xfer_split ? HALF_WORDS : FULL_WORDS; // [RL1] [RL13] [RL15]
                        split_r <= xfer_split;
                        dir_wr_r <= xfer_wr;
                        srs_xf_r <= srs_r;
                        idle_half_r <= ~cnt_r[7]; // [RL15] [RL21]
                        ca7_r <= addr_s[7];
                        ca8_r <= addr_s[8];
                    end
                end
                XF_RUN: begin
                    idx_r <= idx_r + 9'h001;
                    if (idx_r == n_r - 9'h001) begin
                        xf_r <= XF_DRAIN;
                    end
                end
                XF_DRAIN: begin
                    if (!d1_v_r && !d2_v_r) begin
                        xf_r <= XF_IDLE;
                    end
                end
            endcase
        end
    end

    // Addresses are registered so the array sees read addresses a cycle after issue and write addresses two cycles after.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            d1_v_r <= 1'b0;
            d2_v_r <= 1'b0;
            d1_bidx_r <= 8'h00;
            d2_bidx_r <= 8'h00;
            d1_col_r <= 9'h000;
            array_addr_o <= 18'h00000;
            array_rd_o <= 1'b0;
            array_we_o <= 1'b0;
            array_wdata_o <= 16'h0000;
        end else if (ce_i) begin
            d1_v_r <= xf_r == XF_RUN;
            d1_bidx_r <= bidx;
            d1_col_r <= col;
            d2_v_r <= d1_v_r & ~dir_wr_r;
            d2_bidx_r <= d1_bidx_r;
            array_rd_o <= (xf_r == XF_RUN) & ~dir_wr_r;
            array_we_o <= d1_v_r & dir_wr_r; // [RL1]
            array_addr_o <= {row_r, dir_wr_r ? d1_col_r : col};
            array_wdata_o <= buf_bus.b_rdata;
        end
    end

    assign buf_bus.b_addr = dir_wr_r ? bidx : d2_bidx_r;
    assign buf_bus.b_we = ce_i & d2_v_r; // [RL13] [RL15]
    assign buf_bus.b_wdata = array_rdata_i;

    shift_buffer_mem #(
        .DEPTH(256)
    ) u_buf (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .bus(buf_bus)
    );

    // ==========================================================
    // Status word
    always_comb begin
        status = 32'h0000_0000;
        status[ST_CNT_LSB +: 8] = cnt_r;
        status[ST_STOP_LSB +: 8] = stop_r;
        status[ST_PEND_LSB +: 7] = pend_r;
        status[ST_PEND_V] = pend_v_r;
        status[ST_SRS] = srs_r;
        status[ST_WRMODE] = wr_mode_r;
        status[ST_BUSY] = busy;
    end
endmodule
`default_nettype wire

// ===== dv/vram_array_model.sv
`timescale 1ns/100ps
`default_nettype none
module vram_array_model (
    input wire logic clk_i,
    input wire logic [17:0] array_addr_i,
    input wire logic array_rd_i,
    output logic [15:0] array_rdata_o
);
    // ==========================================================
    // Cell array
    // Each cell holds a pattern made from its address.
    // Between reads the bus toggles, so a late sample is caught.
    always_ff @(posedge clk_i) begin
        if (array_rd_i) begin
            array_rdata_o <= {7'h00, array_addr_i[8:0]} + {7'h00, array_addr_i[17:9]};
        end else begin
            array_rdata_o <= ~array_rdata_o;
        end
    end
endmodule
`default_nettype wire

// ===== dv/xfer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module xfer_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [17:0] array_addr_o,
    input wire logic array_rd_o,
    input wire logic array_we_o,
    input wire logic shift_port_gate_n_i,
    input wire logic sdq_oe_o
);
    // ==========================================================
    // Burst length counters
    logic [8:0] rd_run_r;
    logic [8:0] we_run_r;
    always_ff @(posedge clk_i) begin
        rd_run_r <= (reset_i || !array_rd_o) ? 9'h000 : rd_run_r + 9'h001;
    end
    always_ff @(posedge clk_i) begin
        we_run_r <= (reset_i || !array_we_o) ? 9'h000 : we_run_r + 9'h001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================================
    // Properties
    a_rd_run_len: assert property ($fell(array_rd_o) |-> rd_run_r == 9'h080 || rd_run_r == 9'h100)
        else $error("read burst has a wrong word count");
    a_we_run_len: assert property ($fell(array_we_o) |-> we_run_r == 9'h080 || we_run_r == 9'h100)
        else $error("write burst has a wrong word count");
    a_rd_col_step: assert property (array_rd_o && $past(array_rd_o) |->
        array_addr_o[6:0] == $past(array_addr_o[6:0]) + 7'h01)
        else $error("read column does not step by one");
    a_rd_row_hold: assert property (array_rd_o && $past(array_rd_o) |-> $stable(array_addr_o[17:9]))
        else $error("row moved inside a read burst");
    a_we_half_hold: assert property (array_we_o && $past(array_we_o) |-> $stable(array_addr_o[8]))
        else $error("row half moved inside a write burst");
    a_rd_we_apart: assert property (!(array_rd_o && array_we_o))
        else $error("array read and write together");
    a_burst_min: assert property ($rose(array_rd_o) |-> array_rd_o[*8])
        else $error("read burst broke up early");
    a_gate_quiet: assert property (shift_port_gate_n_i[*6] |-> !sdq_oe_o)
        else $error("serial data driven while gated off");
endmodule
bind vram_split_and_stop_transfer xfer_chk u_chk (.clk_i, .reset_i, .array_addr_o, .array_rd_o, .array_we_o,
    .shift_port_gate_n_i, .sdq_oe_o);
`default_nettype wire

// ===== dv/tb_vram_split_and_stop_transfer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_vram_split_and_stop_transfer;
    import vram_xfer_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] paddr_i = 12'h000;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic row_strobe_n_i = 1'b1;
    logic col_strobe_n_i = 1'b1;
    logic [8:0] addr_i = 9'h000;
    logic [2:0] cyc_kind_i = 3'h0;
    logic shift_tick_i = 1'b0;
    logic shift_port_gate_n_i = 1'b1;
    logic [15:0] sdq_o;
    logic sdq_oe_o;
    logic [17:0] array_addr_o;
    logic array_rd_o;
    logic array_we_o;
    logic [15:0] array_wdata_o;
    logic [15:0] array_rdata_i;
    logic [17:0] q[$];
    logic [15:0] wq[$];
    logic [31:0] st;
    logic err;
    int mismatches = 0;
    int n_checks = 0;
    always #4 clk_i = ~clk_i;
    vram_split_and_stop_transfer u_dut (.clk_i, .reset_i, .ce_i(1'b1), .paddr_i, .psel_i, .penable_i,
        .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .row_strobe_n_i, .col_strobe_n_i, .addr_i,
        .cyc_kind_i, .shift_tick_i, .shift_port_gate_n_i, .sdq_i(16'h1234), .sdq_o, .sdq_oe_o,
        .array_addr_o, .array_rd_o, .array_we_o, .array_wdata_o, .array_rdata_i);
    vram_array_model u_arr (.clk_i, .array_addr_i(array_addr_o), .array_rd_i(array_rd_o),
        .array_rdata_o(array_rdata_i));
    always @(posedge clk_i) if (array_rd_o || array_we_o) q.push_back(array_addr_o);
    always @(posedge clk_i) if (array_we_o) wq.push_back(array_wdata_o);
    // ==========================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        cyc(1);
        penable_i <= 1'b1;
        cyc(1);
        while (pready_o !== 1'b1) begin
            cyc(1);
        end
        st = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        cyc(1);
    endtask
    task automatic rs();
        apb(1'b0, OFF_STATUS, 32'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            shift_tick_i <= 1'b1;
            cyc(8);
            shift_tick_i <= 1'b0;
            cyc(8);
        end
    endtask
    // Row strobe stays low 16 clocks and column strobe 8, well clear of the synchroniser delay.
    task automatic pin(input logic [2:0] k, input logic [8:0] r, input logic [8:0] c, input int n);
        int t;
        t = 0;
        q.delete();
        wq.delete();
        cyc_kind_i <= k;
        addr_i <= r;
        row_strobe_n_i <= 1'b0;
        cyc(8);
        if (k != KIND_SETUP) begin
            addr_i <= c;
            col_strobe_n_i <= 1'b0;
        end
        cyc(8);
        row_strobe_n_i <= 1'b1;
        col_strobe_n_i <= 1'b1;
        while (q.size() < n && t < 600) begin
            cyc(1);
            t++;
        end
        cyc(8);
        check("words", q.size(), n);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        cyc(8);
        reset_i <= 1'b0;
        cyc(1);
        rs();
        check("stop", st[15:8], STOP_RST);
        check("mode", st[ST_SRS], 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check("slverr", err, 1'b1);
        pin(KIND_FULL_RD, 9'h055, 9'h1FE, 256);
        rs();
        check("cnt", st[7:0], 8'hFE);
        shift_port_gate_n_i <= 1'b0;
        cyc(8);
        ticks(1);
        check("sdq", sdq_o, 16'h01FE + 16'h0055);
        shift_port_gate_n_i <= 1'b1;
        ticks(1);
        rs();
        check("cnt", st[7:0], 8'h00);
        pin(KIND_SETUP, 9'h13A, 9'h000, 0);
        rs();
        check("stop", st[15:8], 8'h1F);
        check("mode", st[ST_SRS], 1'b1);
        pin(KIND_FULL_RD, 9'h0C3, 9'h185, 256);
        check("first", q[0], {9'h0C3, 9'h080});
        check("last", q[255], {9'h0C3, 9'h1FF});
        pin(KIND_SPLIT_RD, 9'h0C4, 9'h08A, 128);
        check("first", q[0], {9'h0C4, 9'h080});
        rs();
        check("pend", st[23:16], 8'h8A);
        ticks(26);
        rs();
        check("cnt", st[7:0], 8'h9F);
        ticks(1);
        rs();
        check("cnt", st[7:0], 8'h0A);
        pin(KIND_SPLIT_RD, 9'h0C5, 9'h0B0, 128);
        check("first", q[0], {9'h0C5, 9'h180});
        ticks(22);
        rs();
        check("cnt", st[7:0], 8'hB0);
        apb(1'b1, OFF_CTRL, 32'h3);
        rs();
        check("mode", st[ST_SRS], 1'b0);
        pin(KIND_FULL_WR, 9'h0AA, 9'h000, 256);
        check("wdata", wq[0], 16'h0080 + 16'h00C4);
        pin(KIND_SPLIT_WR, 9'h0AB, 9'h105, 128);
        check("first", q[0], {9'h0AB, 9'h180});
        ticks(127);
        rs();
        check("cnt", st[7:0], 8'h7F);
        ticks(1);
        rs();
        check("cnt", st[7:0], 8'h85);
        pin(KIND_SPLIT_WR, 9'h0AB, 9'h180, 128);
        check("first", q[0], {9'h0AB, 9'h100});
        summarize();
    end
    initial begin
        cyc(30000);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
